// file: inc/relay_defs.svh
// Constants for the relay output conditioner
`ifndef RELAY_DEFS_SVH
`define RELAY_DEFS_SVH
`define ON_DELAY_MAX_MS    16'hea60
`define HOLD_TIME_MAX_MS   16'h270f
`define REG_SOURCE         2'h0
`define REG_ON_DELAY       2'h1
`define REG_POLARITY       2'h2
`define REG_HOLD_TIME      2'h3
`define SRC_WIDTH          5
`define SRC_NONE           5'h00
`define SRC_FAULT_FREE     5'h01
`define SRC_BRAKE          5'h02
`define SRC_OUT_CONTACTOR  5'h03
`define SRC_PRECHARGE      5'h04
`define SRC_LINE_CONTACTOR 5'h05
`define TICK_NS            32'h000f_4240
`define CLK_PERIOD_NS      32'h0000_0064
`define TICK_CYCLES        (`TICK_NS / `CLK_PERIOD_NS)
`define RESET_DELAY_MS     16'h0000
`define RESET_HOLD_MS      16'h0000
`define RESET_ACTIVE_LOW   1'b0
`endif

// file: inc/relay_pkg.sv
// Types for the relay output conditioner
package relay_pkg;
    typedef enum logic [1:0] {ST_OFF, ST_DELAY, ST_ON, ST_HOLD} relay_state_e;
    typedef logic [15:0] ms_count_t;
endpackage

// file: design/ms_tick_gen.sv
// Millisecond tick generator from the core clock
`timescale 1ns/1ps
`include "relay_defs.svh"
module ms_tick_gen #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Tick out
    output logic      tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } tick_s;
    tick_s s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 32'(TICK_CYCLES - 1)) begin
            s_d.cnt  = 32'h0000_0000;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 32'h0000_0001;
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign tick = s_q.tick;
endmodule

// file: design/relay_output_conditioner.sv
// Fourth relay output conditioner: source select, delays and polarity
// How it works
// - When the chosen condition turns true the output waits the on-delay, counted in free-running ms ticks so up to 1 ms short, up to 60000 ms.
// - Fault-free, brake, output, precharge and line contactor sources force the on-delay to zero.
// - When the condition turns false the output holds asserted for the hold time, up to 9999 ms.
// - Fault-free, brake, precharge and line contactor sources force the hold time to zero.
// - Active-high drives 1 while asserted, active-low drives 0 while asserted.
// - Fault-free, brake, precharge and line contactor sources lock polarity to active-high.
// - The relay and its settings exist and take writes only when the option card is fitted.
// - Sources match the second relay; reset gives no source, zero timers, active-high.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "relay_defs.svh"
module relay_output_conditioner #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
    parameter int unsigned NUM_SOURCES = 32
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // Option card presence
    input  wire logic                   option_card_fitted,
    // Internal drive conditions, bit per source code
    input  wire logic [NUM_SOURCES-1:0] drive_conditions,
    // Register port
    input  wire logic [1:0]             reg_addr,
    input  wire logic [15:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [15:0]            reg_rdata,
    // Relay coil
    output logic                        relay_four_out
);
    localparam logic [1:0] A_SRC  = `REG_SOURCE;
    localparam logic [1:0] A_DLY  = `REG_ON_DELAY;
    localparam logic [1:0] A_POL  = `REG_POLARITY;
    localparam logic [1:0] A_HOLD = `REG_HOLD_TIME;

    typedef struct packed {
        logic [`SRC_WIDTH-1:0]   relay_four_source_select;
        relay_pkg::ms_count_t    relay_four_on_delay;
        logic                    relay_four_polarity;
        relay_pkg::ms_count_t    relay_four_hold_time;
        relay_pkg::relay_state_e state;
        relay_pkg::ms_count_t    timer;
        logic [15:0]             rdata;
        logic                    out;
    } cond_s;
    cond_s s_q, s_d;
    logic tick;

    ms_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (tick)
    );

    // Fault-free, contactor and brake sources switch with no on-delay at all
    function automatic logic locks_delay(input logic [`SRC_WIDTH-1:0] s);
        case (s)
            `SRC_FAULT_FREE,
            `SRC_BRAKE,
            `SRC_OUT_CONTACTOR,
            `SRC_PRECHARGE,
            `SRC_LINE_CONTACTOR: return 1'b1;
            default:             return 1'b0;
        endcase
    endfunction

    // Output contactor keeps its hold and polarity; the rest are fixed
    function automatic logic locks_all(input logic [`SRC_WIDTH-1:0] s);
        case (s)
            `SRC_FAULT_FREE,
            `SRC_BRAKE,
            `SRC_PRECHARGE,
            `SRC_LINE_CONTACTOR: return 1'b1;
            default:             return 1'b0;
        endcase
    endfunction

    // Out-of-range writes saturate rather than wrap
    function automatic relay_pkg::ms_count_t clampv(input logic [15:0] v,
                                                    input logic [15:0] mx);
        if (v > mx) begin
            return mx;
        end
        return v;
    endfunction

    // Both intervals end once the ms count reaches the limit
    function automatic logic interval_done(input relay_pkg::ms_count_t t,
                                           input relay_pkg::ms_count_t lim);
        return t >= lim;
    endfunction

    // Both intervals advance only on the shared ms tick
    function automatic relay_pkg::ms_count_t interval_step(input relay_pkg::ms_count_t t,
                                                           input logic                 tk);
        if (tk) begin
            return t + 16'h0001;
        end
        return t;
    endfunction

    logic                 cond_now;
    relay_pkg::ms_count_t eff_delay;
    relay_pkg::ms_count_t eff_hold;
    logic                 eff_low;
    logic                 asserted;

    always_comb begin
        s_d = s_q;
        // Source none reads as an inactive condition
        cond_now = (s_q.relay_four_source_select != `SRC_NONE)
            && drive_conditions[s_q.relay_four_source_select];
        eff_delay = s_q.relay_four_on_delay;
        eff_hold  = s_q.relay_four_hold_time;
        eff_low   = s_q.relay_four_polarity;
        // Stored values survive a lock, so they return if the source changes back
        if (locks_delay(s_q.relay_four_source_select)) begin
            eff_delay = 16'h0000;
        end
        if (locks_all(s_q.relay_four_source_select)) begin
            eff_hold = 16'h0000;
            eff_low  = 1'b0;
        end

        // Settings take writes only with the card fitted
        if (reg_wr && option_card_fitted) begin
            case (reg_addr)
                A_SRC:  s_d.relay_four_source_select = reg_wdata[`SRC_WIDTH-1:0];
                A_DLY:  s_d.relay_four_on_delay = clampv(reg_wdata, `ON_DELAY_MAX_MS);
                A_POL:  s_d.relay_four_polarity = reg_wdata[0];
                A_HOLD: s_d.relay_four_hold_time = clampv(reg_wdata, `HOLD_TIME_MAX_MS);
                default: ;
            endcase
        end

        // Read data stands one cycle, then returns to zero
        s_d.rdata = 16'h0000;
        if (reg_rd && option_card_fitted) begin
            case (reg_addr)
                A_SRC:  s_d.rdata = {11'h000, s_q.relay_four_source_select};
                A_DLY:  s_d.rdata = eff_delay;
                A_POL:  s_d.rdata = {15'h0000, eff_low};
                A_HOLD: s_d.rdata = eff_hold;
                default: s_d.rdata = 16'h0000;
            endcase
        end

        // Timers compare against ms ticks; a change mid-interval drops back and restarts
        case (s_q.state)
            relay_pkg::ST_OFF: begin
                s_d.timer = 16'h0000;
                if (cond_now) begin
                    if (eff_delay == 16'h0000) begin
                        s_d.state = relay_pkg::ST_ON;
                    end else begin
                        s_d.state = relay_pkg::ST_DELAY;
                    end
                end
            end
            relay_pkg::ST_DELAY: begin
                if (!cond_now) begin
                    s_d.state = relay_pkg::ST_OFF;
                    s_d.timer = 16'h0000;
                end else if (interval_done(s_q.timer, eff_delay)) begin
                    s_d.state = relay_pkg::ST_ON;
                end else begin
                    s_d.timer = interval_step(s_q.timer, tick);
                end
            end
            relay_pkg::ST_ON: begin
                s_d.timer = 16'h0000;
                if (!cond_now) begin
                    if (eff_hold == 16'h0000) begin
                        s_d.state = relay_pkg::ST_OFF;
                    end else begin
                        s_d.state = relay_pkg::ST_HOLD;
                    end
                end
            end
            relay_pkg::ST_HOLD: begin
                if (cond_now) begin
                    s_d.state = relay_pkg::ST_ON;
                    s_d.timer = 16'h0000;
                end else if (interval_done(s_q.timer, eff_hold)) begin
                    s_d.state = relay_pkg::ST_OFF;
                end else begin
                    s_d.timer = interval_step(s_q.timer, tick);
                end
            end
            default: s_d.state = relay_pkg::ST_OFF;
        endcase

        // Without the card the relay does not exist; keep it de-energised
        asserted = (s_d.state == relay_pkg::ST_ON) || (s_d.state == relay_pkg::ST_HOLD);
        if (!option_card_fitted) begin
            s_d.out = 1'b0;
        end else begin
            s_d.out = asserted ^ eff_low;
        end
    end

    // Factory state: no source, zero intervals, active-high, relay off
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q.relay_four_source_select <= `SRC_NONE;
            s_q.relay_four_on_delay      <= `RESET_DELAY_MS;
            s_q.relay_four_polarity      <= `RESET_ACTIVE_LOW;
            s_q.relay_four_hold_time     <= `RESET_HOLD_MS;
            s_q.state                    <= relay_pkg::ST_OFF;
            s_q.timer                    <= 16'h0000;
            s_q.rdata                    <= 16'h0000;
            s_q.out                      <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata      = s_q.rdata;
    assign relay_four_out = s_q.out;
endmodule

// file: tb/relay_output_conditioner_chk.sv
// Assertion checker on the relay output conditioner ports
`timescale 1ns/1ps
module relay_output_conditioner_chk #(
    parameter int unsigned NUM_SOURCES = 32
) (
    input wire logic                   core_clk,
    input wire logic                   rst,
    input wire logic                   option_card_fitted,
    input wire logic [NUM_SOURCES-1:0] drive_conditions,
    input wire logic [1:0]             reg_addr,
    input wire logic [15:0]            reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [15:0]            reg_rdata,
    input wire logic                   relay_four_out
);
    // Shadow source, so locked behaviour is judged without the body
    logic [4:0] src_q;
    logic       lk;
    logic       sel;
    always_ff @(posedge core_clk or posedge rst)
        if (rst) src_q <= 5'h00;
        else if (reg_wr && option_card_fitted && reg_addr == 2'h0) src_q <= reg_wdata[4:0];
    assign lk = option_card_fitted && src_q inside {5'h01, 5'h02, 5'h04, 5'h05};
    assign sel = drive_conditions[src_q];
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_reset_quiet: assert property (disable iff (1'b0) rst |-> !relay_four_out && !reg_rdata)
        else $error("output active in reset");
    a_absent_dark: assert property (!option_card_fitted && $past(!option_card_fitted) |-> !relay_four_out)
        else $error("relay driven without card");
    a_absent_read: assert property ($past(reg_rd && !option_card_fitted) |-> reg_rdata == 16'h0000)
        else $error("read without card not zero");
    a_src_read: assert property (reg_rd && option_card_fitted && reg_addr == 2'h0 |=> reg_rdata == {11'h000, src_q})
        else $error("source readback wrong");
    a_delay_locked: assert property (reg_rd && option_card_fitted && reg_addr == 2'h1 && src_q inside {[5'h01:5'h05]} |=> reg_rdata == 16'h0000)
        else $error("locked delay not zero");
    a_hold_locked: assert property (reg_rd && lk && reg_addr == 2'h3 |=> reg_rdata == 16'h0000)
        else $error("locked hold not zero");
    a_pol_locked: assert property (reg_rd && lk && reg_addr == 2'h2 |=> reg_rdata == 16'h0000)
        else $error("locked polarity not high");
    a_locked_follow: assert property (lk && $past(lk) |-> relay_four_out == $past(sel))
        else $error("locked output not following");
endmodule

// file: tb/relay_contact_model.sv
// Relay contact: mechanical contact following the coil drive
`timescale 1ns/1ps
module relay_contact_model (
    // Clock
    input  wire logic core_clk,
    // Coil and contact
    input  wire logic coil,
    output logic      contact_closed
);
    // Travel time only; bounce is not modelled
    logic [2:0] travel_q;
    always_ff @(posedge core_clk)
        travel_q <= {travel_q[1:0], coil};
    assign contact_closed = travel_q[2];
endmodule

// file: tb/tb.sv
// Self-checking bench for the relay output conditioner
`timescale 1ns/1ps
module tb;
    logic        core_clk, rst, option_card_fitted, reg_wr, reg_rd, relay_four_out, contact;
    logic [31:0] drive_conditions;
    logic [1:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, got;
    int          mismatches, checks_done, cycles;
    // Row: source, address, written, expected read
    logic [38:0] rows [4] = '{{5'h06, 2'h1, 16'hffff, 16'hea60}, {5'h06, 2'h1, 16'h04d2, 16'h04d2},
        {5'h06, 2'h3, 16'h2710, 16'h270f}, {5'h06, 2'h2, 16'h0001, 16'h0001}};
    relay_output_conditioner #(.TICK_CYCLES(10)) dut_u (.core_clk(core_clk), .rst(rst),
        .option_card_fitted(option_card_fitted), .drive_conditions(drive_conditions),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .relay_four_out(relay_four_out));
    relay_contact_model load_u (.core_clk(core_clk), .coil(relay_four_out), .contact_closed(contact));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic conclude();
        $display("mismatches %0d, checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h, wanted %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [1:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask
    task automatic cond(input int b, input logic v);
        @(posedge core_clk);
        drive_conditions[b] <= v;
    endtask
    // Bounded wait, sampled off the edge
    task automatic await(input logic v, input int lim);
        #1;
        repeat (lim) if (relay_four_out !== v) #100;
        chk({15'h0000, relay_four_out}, {15'h0000, v});
    endtask
    task automatic still(input logic v, input int k);
        repeat (k) @(posedge core_clk);
        #1 chk({15'h0000, relay_four_out}, {15'h0000, v});
    endtask
    initial begin
        // Rise after time zero so the asynchronous reset is seen for sure
        rst = 1'b0;
        option_card_fitted = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 16'h0000;
        drive_conditions = 32'h0000_0000;
        #1 rst = 1'b1;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        bus(1'b1, 2'h0, 16'h0006);
        bus(1'b0, 2'h0, 16'h0000);
        chk(got, 16'h0000);
        option_card_fitted <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, i[1:0], 16'h0000);
            chk(got, 16'h0000);
        end
        foreach (rows[i]) begin
            bus(1'b1, 2'h0, {11'h000, rows[i][38:34]});
            bus(1'b1, rows[i][33:32], rows[i][31:16]);
            bus(1'b0, rows[i][33:32], 16'h0000);
            chk(got, rows[i][15:0]);
        end
        for (int s = 1; s < 6; s++) begin
            bus(1'b1, 2'h0, s[15:0]);
            for (int a = 1; a < 4; a++) begin
                bus(1'b1, a[1:0], 16'h0001);
                bus(1'b0, a[1:0], 16'h0000);
                chk(got, (s == 3 && a != 1) ? 16'h0001 : 16'h0000);
            end
        end
        cond(5, 1'b1);
        await(1'b1, 3);
        cond(5, 1'b0);
        await(1'b0, 3);
        bus(1'b1, 2'h0, 16'h0006);
        bus(1'b1, 2'h1, 16'h0003);
        bus(1'b1, 2'h3, 16'h0002);
        bus(1'b1, 2'h2, 16'h0001);
        await(1'b1, 3);
        cond(6, 1'b1);
        still(1'b1, 20);
        await(1'b0, 15);
        still(1'b0, 4);
        chk({15'h0000, contact}, 16'h0000);
        cond(6, 1'b0);
        still(1'b0, 10);
        await(1'b1, 20);
        cond(6, 1'b1);
        still(1'b1, 10);
        cond(6, 1'b0);
        cond(6, 1'b1);
        still(1'b1, 20);
        await(1'b0, 15);
        cond(6, 1'b0);
        cond(6, 1'b1);
        still(1'b0, 30);
        cond(6, 1'b0);
        await(1'b1, 25);
        option_card_fitted <= 1'b0;
        still(1'b0, 3);
        conclude();
    end
endmodule
bind relay_output_conditioner relay_output_conditioner_chk #(.NUM_SOURCES(NUM_SOURCES)) chk_u (
    .core_clk(core_clk), .rst(rst), .option_card_fitted(option_card_fitted),
    .drive_conditions(drive_conditions), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .relay_four_out(relay_four_out));
